// [tb_wdu_unit.sv]
// tb_wdu_unit.sv: register-level tests of wdu_unit
// assumes wdu_ls_osc ticks every 20 system cycles
`timescale 1ns/1ps
`include "wdu_params.svh"
module tb_wdu_unit;
  localparam int PER = 1280; // 64 ticks of 20 cycles
  logic clock_i = 1'b0, rst_n_i = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic ext_s = 1'b0, ce_s = 1'b1, lsclk, sys_rst, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] irq_cnt = 8'h00, rst_cnt = 8'h00;
  int miscompares = 0, checks = 0, cyc = 0;
  initial forever #2.5 clock_i = ~clock_i;
  wdu_ls_osc wdu_ls_osc_i (.clock_i(clock_i), .lsclk_o(lsclk));
  wdu_unit wdu_unit_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_s),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .lsclk_i(lsclk), .ext_rst_i(ext_s), .rdata_o(rdata),
    .sys_reset_o(sys_rst), .irq_o(irq));
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
    if (sys_rst === 1'b1) rst_cnt <= rst_cnt + 8'h01;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 cmp("rdata", e, rdata);
  endtask
  // clears every 40 ticks, well inside the 64-tick interval
  task keep(input logic [7:0] k1, input logic [7:0] k2);
    repeat (3) begin
      repeat (800) @(posedge clock_i);
      wr(`WDU_CTL_ADDR, k1);
      wr(`WDU_CTL_ADDR, k2);
    end
  endtask
  initial begin
    logic [7:0] n;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rc(`WDU_CTL_ADDR, 8'h00);
    rc(`WDU_CAUSE_ADDR, 8'h00);
    wr(`WDU_CTL_ADDR, 8'hff);
    rc(`WDU_CTL_ADDR, 8'h0f);
    for (int i = 0; i < 2000 && irq_cnt == 8'h00; i++) @(posedge clock_i);
    n = irq_cnt;
    repeat (PER - 10) @(posedge clock_i);
    cmp("irq early", n, irq_cnt);
    repeat (20) @(posedge clock_i);
    cmp("irq period", n + 8'h01, irq_cnt);
    cmp("timer reset", 8'h00, rst_cnt);
    n = irq_cnt;
    keep(8'h1f, 8'h1f);
    cmp("timer clear", n, irq_cnt);
    wr(`WDU_CTL_ADDR, 8'h07);
    repeat (2000) @(posedge clock_i);
    cmp("timer stop", n, irq_cnt);
    wr(`WDU_CTL_ADDR, 8'h0b);
    wr(`WDU_CTL_ADDR, 8'h07);
    rc(`WDU_CTL_ADDR, 8'h0b);
    wr(`WDU_CTL_ADDR, 8'h0a);
    rc(`WDU_CTL_ADDR, 8'h0a);
    keep(8'hab, 8'h5b);
    cmp("wdog cleared", 8'h00, rst_cnt);
    wr(`WDU_CTL_ADDR, 8'ha3);
    wr(`WDU_CTL_ADDR, 8'h63);
    repeat (PER + 20) @(posedge clock_i);
    cmp("wdog fire", 8'h01, rst_cnt);
    cmp("wdog irq", n, irq_cnt);
    rc(`WDU_CAUSE_ADDR, 8'h02);
    rc(`WDU_CTL_ADDR, 8'h00);
    @(posedge clock_i);
    ext_s <= 1'b1;
    @(posedge clock_i);
    ext_s <= 1'b0;
    rc(`WDU_CAUSE_ADDR, 8'h01);
    wr(`WDU_CTL_ADDR, 8'h0f);
    ce_s <= 1'b0;
    repeat (2000) @(posedge clock_i);
    cmp("ce freeze", n, irq_cnt);
    ce_s <= 1'b1;
    repeat (PER + 40) @(posedge clock_i);
    cmp("ce resume", n + 8'h01, irq_cnt);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rc(`WDU_CTL_ADDR, 8'h00);
    rc(`WDU_CAUSE_ADDR, 8'h00);
    end_sim();
  end
endmodule // tb_wdu_unit

// [wdu_ls_osc.sv]
// wdu_ls_osc.sv: free-running low-speed clock source model
// assumes the period is shortened to keep the run short
`timescale 1ns/1ps
module wdu_ls_osc #(
  parameter int HALF = 10
) (
  input wire logic clock_i,
  output logic lsclk_o
);
  int cnt = 0;
  initial lsclk_o = 1'b0;
  // oscillator runs free, so it never stands still
  always @(posedge clock_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) lsclk_o <= ~lsclk_o;
  end
endmodule // wdu_ls_osc

// [wdu_params.svh]
// wdu_params.svh: offsets, field positions and timing counts of wdog_unit
// assumes a 200 MHz system clock and a 32.768 kHz low-speed tick input
`ifndef WDU_PARAMS_SVH
`define WDU_PARAMS_SVH

`define WDU_CTL_ADDR 8'hc9
`define WDU_CAUSE_ADDR 8'hca

`define WDU_KEY_HI 7
`define WDU_KEY_LO 4
`define WDU_KEY_CLR0 4
`define WDU_KEY_ARM 4'ha
`define WDU_KEY_DONE 4'h5

`define WDU_TERM_00 15'h7fff
`define WDU_TERM_01 15'h1fff
`define WDU_TERM_10 15'h01ff
`define WDU_TERM_11 15'h003f

`define WDU_CLK_PS 5000
`define WDU_LS_HALF_PS 15258789
`define WDU_HALF_CYC (`WDU_LS_HALF_PS / `WDU_CLK_PS)

`endif

// [wdu_pkg.sv]
// wdu_pkg.sv: types shared by wdog_unit
// assumes nothing beyond a SystemVerilog compiler
package wdu_pkg;

  typedef enum logic {
    WDU_MODE_WDOG,
    WDU_MODE_TIMER
  } wdu_mode_e;

  typedef enum logic [1:0] {
    WDU_CAUSE_POR,
    WDU_CAUSE_EXT,
    WDU_CAUSE_WDOG
  } wdu_cause_e;

  typedef struct packed {
    logic en;
    wdu_mode_e mode;
    logic [1:0] intv;
  } wdu_ctrl_s;

endpackage

// [wdu_unit.sv]
// wdu_unit.sv: watchdog / interval timer with its control register
// assumes a plain register port and a low-speed tick level on lsclk_i
//
// Behaviour
// - after any reset the unit is disabled
// - hidden 15-bit counter advanced by low-speed clock
// - mode bit 2: 0 watchdog, 1 timer
// - writing enable 1 starts counting
// - watchdog mode enable cannot be cleared
// - watchdog mode enabled locks the mode bit
// - interval 00..11 gives 32768/8192/512/64 periods
// - interval stays writable while running
// - watchdog expiry resets the system
// - 0xa then 0x5 within half period clears
// - started sequence honoured, incomplete one ignored
// - watchdog mode never raises an interrupt
// - timer expiry raises an interrupt
// - timer mode key bit 0 clears counter
// - timer mode enable 0 stops, 1 restarts
// - timer expiry never resets the system
// - key writes ignored while disabled
// - key field always reads zero
// - reset cause reads 10 after watchdog reset
`timescale 1ns/1ps

`include "wdu_params.svh"

module wdu_unit import wdu_pkg::*; #(
  parameter int CNT_W = 15,
  parameter int WIN_W = 12
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic lsclk_i,
  input wire logic ext_rst_i,
  output logic [7:0] rdata_o,
  output logic sys_reset_o,
  output logic irq_o
);

  localparam logic [WIN_W-1:0] HALF_CYC = WIN_W'(`WDU_HALF_CYC);

  wdu_ctrl_s ctrl;
  wdu_cause_e cause;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;
  logic [WIN_W-1:0] win;
  logic [3:0] key;
  logic ls_prev;
  logic tick;
  logic wr_ctl;
  logic wd_on;
  logic tm_on;
  logic armed;
  logic pend;
  logic reach;
  logic seq_done;
  logic tclr;
  logic fire;

  // the tick is a plain level here; one clock keeps the crossing trivial
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ls_prev <= 1'b0;
    end else if (ce_i) begin
      ls_prev <= lsclk_i;
    end
  end

  assign tick = lsclk_i && !ls_prev;
  assign wr_ctl = wr_i && (addr_i == `WDU_CTL_ADDR);
  assign key = wdata_i[`WDU_KEY_HI:`WDU_KEY_LO];
  assign wd_on = ctrl.en && (ctrl.mode == WDU_MODE_WDOG);
  assign tm_on = ctrl.en && (ctrl.mode == WDU_MODE_TIMER);

  always_comb begin
    case (ctrl.intv)
      2'b00: term = CNT_W'(`WDU_TERM_00);
      2'b01: term = CNT_W'(`WDU_TERM_01);
      2'b10: term = CNT_W'(`WDU_TERM_10);
      default: term = CNT_W'(`WDU_TERM_11);
    endcase
  end

  // >= so that a shortened interval takes effect at once
  assign reach = tick && ctrl.en && (cnt >= term);
  assign seq_done = wr_ctl && wd_on && armed && (key == `WDU_KEY_DONE);
  assign tclr = wr_ctl && tm_on && wdata_i[`WDU_KEY_CLR0];
  // expiry during an open sequence waits for its outcome
  assign fire = wd_on && ((reach && !armed) || (pend && !armed));

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl <= '0;
    end else if (ce_i) begin
      if (fire || ext_rst_i) begin
        ctrl <= '0;
      end else if (wr_ctl) begin
        ctrl.intv <= wdata_i[1:0];
        if (!wd_on) begin
          ctrl.mode <= wdu_mode_e'(wdata_i[2]);
          ctrl.en <= wdata_i[3];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (!ctrl.en) begin
        cnt <= '0;
      end else if (seq_done || tclr) begin
        cnt <= '0;
      end else if (tick) begin
        if (cnt >= term) begin
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      armed <= 1'b0;
      win <= '0;
    end else if (ce_i) begin
      if (wr_ctl && wd_on) begin
        armed <= (key == `WDU_KEY_ARM);
        win <= HALF_CYC;
      end else if (!ctrl.en) begin
        armed <= 1'b0;
      end else if (armed) begin
        if (win == '0) begin
          armed <= 1'b0;
        end else begin
          win <= win - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pend <= 1'b0;
    end else if (ce_i) begin
      if (!wd_on || seq_done || fire) begin
        pend <= 1'b0;
      end else if (reach && armed) begin
        pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sys_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sys_reset_o <= fire;
      irq_o <= reach && tm_on;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cause <= WDU_CAUSE_POR;
    end else if (ce_i) begin
      if (fire) begin
        cause <= WDU_CAUSE_WDOG;
      end else if (ext_rst_i) begin
        cause <= WDU_CAUSE_EXT;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      if (rd_i && addr_i == `WDU_CTL_ADDR) begin
        rdata_o <= {4'h0, ctrl};
      end else if (rd_i && addr_i == `WDU_CAUSE_ADDR) begin
        rdata_o <= {6'h00, cause};
      end else begin
        rdata_o <= '0;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  reset_disables_a: assert property (
    $past(!rst_n_i) |-> !ctrl.en)
    else $error("unit enabled right after reset");

  count_frozen_a: assert property (
    !ctrl.en |=> cnt == '0)
    else $error("counter moved while disabled");

  en_locked_a: assert property (
    wd_on && !fire && !ext_rst_i |=> ctrl.en)
    else $error("watchdog was disabled by a write");

  mode_locked_a: assert property (
    wd_on && !fire && !ext_rst_i |=> ctrl.mode == WDU_MODE_WDOG)
    else $error("watchdog mode changed while enabled");

  irq_cause_a: assert property (
    ce_i && $rose(irq_o) |-> $past(tm_on))
    else $error("interrupt outside timer mode");

  reset_cause_a: assert property (
    ce_i && sys_reset_o |-> $past(wd_on) && cause == WDU_CAUSE_WDOG)
    else $error("system reset without watchdog expiry");

  seq_clears_a: assert property (
    ce_i && seq_done |=> cnt == '0 ##1 !sys_reset_o)
    else $error("clear sequence did not clear");

  timer_clear_a: assert property (
    ce_i && tclr |=> cnt == '0)
    else $error("timer clear bit ignored");

  key_reads_zero_a: assert property (
    ce_i && rd_i && addr_i == `WDU_CTL_ADDR |=> rdata_o[7:4] == 4'h0)
    else $error("key field read nonzero");

  cause_after_fire_a: assert property (
    ce_i && fire |=> !ctrl.en && cause == WDU_CAUSE_WDOG)
    else $error("watchdog reset not recorded");

  // register write and read side
  mode_write_a: assert property (
    ce_i && wr_ctl && !wd_on && !fire && !ext_rst_i
    |=> ctrl.mode == wdu_mode_e'($past(wdata_i[2])))
    else $error("mode bit write not taken");

  en_write_a: assert property (
    ce_i && wr_ctl && !wd_on && !fire && !ext_rst_i
    |=> ctrl.en == $past(wdata_i[3]))
    else $error("enable bit write not taken");

  intv_write_a: assert property (
    ce_i && wr_ctl && !fire && !ext_rst_i
    |=> ctrl.intv == $past(wdata_i[1:0]))
    else $error("interval write not taken");

  ctl_steady_a: assert property (
    ce_i && !wr_ctl && !fire && !ext_rst_i |=> $stable(ctrl))
    else $error("control changed without a write");

  ctl_read_a: assert property (
    ce_i && rd_i && addr_i == `WDU_CTL_ADDR
    |=> rdata_o[3:0] == $past(ctrl))
    else $error("control read back wrong");

  cause_read_a: assert property (
    ce_i && rd_i && addr_i == `WDU_CAUSE_ADDR
    |=> rdata_o == {6'h00, $past(cause)})
    else $error("cause read back wrong");

  unmapped_read_a: assert property (
    ce_i && rd_i && addr_i != `WDU_CTL_ADDR && addr_i != `WDU_CAUSE_ADDR
    |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");

  rdata_idle_a: assert property (
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data without a read");

  ext_clears_a: assert property (
    ce_i && ext_rst_i && !fire |=> !ctrl.en && cause == WDU_CAUSE_EXT)
    else $error("external reset did not disable");

  // counting
  count_step_a: assert property (
    ce_i && tick && ctrl.en && !seq_done && !tclr && cnt < term
    |=> cnt == $past(cnt) + 1'b1)
    else $error("counter did not advance on tick");

  count_hold_a: assert property (
    ce_i && !tick && ctrl.en && !seq_done && !tclr |=> $stable(cnt))
    else $error("counter moved without a tick");

  tick_single_a: assert property (
    ce_i && tick |=> !tick)
    else $error("tick lasted more than one cycle");

  state_frozen_a: assert property (
    !ce_i |=> $stable(cnt) && $stable(ctrl) && $stable(armed) &&
      $stable(irq_o) && $stable(sys_reset_o) && $stable(rdata_o))
    else $error("state moved while clock enable low");

  disabled_idle_a: assert property (
    ce_i && !ctrl.en |=> !irq_o && !sys_reset_o)
    else $error("output pulse while disabled");

  // timer mode
  irq_on_term_a: assert property (
    ce_i && tick && tm_on && cnt >= term |=> irq_o)
    else $error("timer expiry without interrupt");

  irq_pulse_a: assert property (
    ce_i && irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");

  irq_tick_a: assert property (
    $rose(irq_o) |-> $past(tick))
    else $error("interrupt without a tick");

  timer_stop_a: assert property (
    ce_i && tm_on && wr_ctl && !wdata_i[3] && !ext_rst_i |=> !ctrl.en)
    else $error("timer did not stop");

  timer_no_reset_a: assert property (
    ce_i && tm_on |=> !sys_reset_o)
    else $error("system reset in timer mode");

  // watchdog mode
  wd_no_irq_a: assert property (
    ce_i && wd_on |=> !irq_o)
    else $error("interrupt in watchdog mode");

  expiry_fires_a: assert property (
    ce_i && reach && wd_on && !armed |=> sys_reset_o)
    else $error("watchdog expiry without reset");

  reset_pulse_a: assert property (
    ce_i && sys_reset_o |=> !sys_reset_o)
    else $error("system reset longer than one cycle");

  seq_arms_a: assert property (
    ce_i && wr_ctl && wd_on && key == `WDU_KEY_ARM
    |=> armed && win == HALF_CYC)
    else $error("first key did not open the window");

  armed_holds_a: assert property (
    ce_i && wd_on && armed && reach && !seq_done
    |=> !sys_reset_o && pend)
    else $error("expiry during open sequence not held");

  pend_fires_a: assert property (
    ce_i && pend && !armed && wd_on |=> sys_reset_o)
    else $error("held expiry never fired");

  window_lapse_a: assert property (
    ce_i && armed && win == '0 && !wr_ctl && ctrl.en |=> !armed)
    else $error("clear window did not close");

  incomplete_a: assert property (
    ce_i && wr_ctl && wd_on && armed && key != `WDU_KEY_DONE &&
      key != `WDU_KEY_ARM |=> !armed)
    else $error("wrong second key kept the window");

  disabled_key_a: assert property (
    ce_i && wr_ctl && !ctrl.en |=> !armed)
    else $error("key write acted while disabled");

  wd_fire_c: cover property (ce_i && fire);
  timer_irq_c: cover property (ce_i && reach && tm_on);
  seq_ok_c: cover property (ce_i && seq_done);
  late_seq_c: cover property (ce_i && pend && seq_done);
  ce_freeze_c: cover property (!ce_i && ctrl.en);

endmodule // wdu_unit
